// file: verification/test_ladder_reference_control.sv
/*
 * Self-checking bench for the ladder reference control block: AHB-Lite
 * register access, control field outputs, tap decode and reset behaviour.
 * Assumes the package and design files under verilog/ are compiled first.
 */
`default_nettype none

module test_ladder_reference_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic arst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic ladder_power_enable;
    logic reference_pin_connect;
    logic reference_source_select;
    logic [4:0] ladder_level_code;
    logic [31:0] ladder_tap_select;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] wd;
    logic [7:0] v;
    logic [7:0] corner [4];

    // single slave, so its ready output is the bus ready
    lrc_top lrc_top_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ladder_power_enable(ladder_power_enable),
        .reference_pin_connect(reference_pin_connect),
        .reference_source_select(reference_source_select),
        .ladder_level_code(ladder_level_code), .ladder_tap_select(ladder_tap_select)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] tap_of(logic [7:0] r);
        return r[lrc_pkg::POWER_BIT] ? (32'h00000001 << r[4:0]) : 32'h00000000;
    endfunction

    // called just after a rising edge; ends at the data-phase edge
    task automatic bus(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= lrc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask

    task automatic check_state(logic [7:0] r);
        chk("power", {31'h0, r[7]}, {31'h0, ladder_power_enable});
        chk("pin", {31'h0, r[6]}, {31'h0, reference_pin_connect});
        chk("source", {31'h0, r[5]}, {31'h0, reference_source_select});
        chk("level", {27'h0, r[4:0]}, {27'h0, ladder_level_code});
        chk("tap", tap_of(r), ladder_tap_select);
        chk("resp", {31'h0, lrc_pkg::HRESP_OKAY}, {31'h0, hresp});
        chk("ready", 32'h00000001, {31'h0, hreadyout});
    endtask

    // hang guard: a few hundred cycles are expected
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        corner = '{8'hFF, 8'h80, 8'hDF, 8'h1F};
        void'($urandom(96524));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        check_state(8'h00);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("reset read", {24'h0, lrc_pkg::CTRL_RESET}, rd);
        for (int i = 0; i < 40; i++) begin
            v = (i < 4) ? corner[i] : 8'($urandom);
            wd = $urandom;
            wd[7:0] = v;
            bus(1'b1, 32'h0, wd, rd);
            bus(1'b0, 32'h0, $urandom, rd);
            chk("readback", {24'h0, v}, rd);
            // give the outputs time to settle before relying on them
            repeat (2) @(posedge sys_clk);
            check_state(v);
        end
        // unmapped word: writes ignored, reads zero
        bus(1'b1, 32'h00000004, 32'h000000FF, rd);
        bus(1'b0, 32'h00000004, 32'h0, rd);
        chk("unmapped read", 32'h00000000, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("kept read", {24'h0, v}, rd);
        // power the ladder down before a long quiet spell
        v[lrc_pkg::POWER_BIT] = 1'h0;
        bus(1'h1, 32'h00000000, {24'h0, v}, rd);
        // deselected traffic must not disturb the register
        repeat (50) begin
            hwrite <= 1'b1;
            htrans <= lrc_pkg::HTRANS_NONSEQ;
            hwdata <= $urandom;
            @(posedge sys_clk);
        end
        htrans <= 2'h0;
        repeat (3) @(posedge sys_clk);
        check_state(v);
        bus(1'h0, 32'h0, 32'h0, rd);
        chk("quiet read", {24'h0, v}, rd);
        // reset in mid-run: the clear must show before the next edge
        bus(1'h1, 32'h0, 32'h000000FF, rd);
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'h0;
        #1 check_state(8'h00);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("mid reset read", 32'h00000000, rd);
        complete_run();
    end
endmodule

`default_nettype wire

// file: verilog/lrc_bus_if.sv
/*
 * Carrier between the bus slave and the tap decoder: stored control fields.
 * Assumes both ends sit in the same clock domain.
 */
`default_nettype none

interface lrc_bus_if;
    logic [4:0] level_code;
    logic power_enable;
    logic [31:0] tap_select;
    modport ctrl (output level_code, output power_enable, input tap_select);
    modport tap (input level_code, input power_enable, output tap_select);
endinterface

`default_nettype wire

// file: verilog/lrc_pkg.sv
/*
 * Package for the ladder reference control block: register offset, field
 * positions, reset value and bus encodings.
 * Assumes an AHB-Lite slave with 32-bit data and single word transfers.
 */
`default_nettype none

package lrc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] ADDR_MASK = 12'hFFC;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int POWER_BIT = 7;
    localparam int PIN_BIT = 6;
    localparam int SOURCE_BIT = 5;
    localparam int LEVEL_MSB = 4;
    localparam int LEVEL_WIDTH = 5;
    localparam int TAP_COUNT = 32;
    localparam logic [4:0] LEVEL_MAX = 5'h1F;
    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

`default_nettype wire

// file: verilog/lrc_tap_decode.sv
/*
 * Registered one-hot tap decoder for the 32-tap ladder.
 * Assumes level and power fields come from registers on the same clock.
 */
`default_nettype none

module lrc_tap_decode (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // control fields
    lrc_bus_if.tap bus
);
    logic [31:0] tap_select;
    logic [31:0] next_tap_select;

    function automatic logic [31:0] lrc_onehot(input logic [4:0] code);
        lrc_onehot = 32'h0000_0001 << code;
    endfunction

    // ------------------------------------------------------------
    // tap select
    // ------------------------------------------------------------
    always_comb begin
        // no tap while powered down, so the ladder draws nothing
        next_tap_select = bus.power_enable ? lrc_onehot(bus.level_code) : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_select <= 32'h0000_0000;
        end else begin
            tap_select <= next_tap_select;
        end
    end

    assign bus.tap_select = tap_select;

    AST_TAP_ONEHOT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(bus.power_enable) |-> tap_select == (32'h0000_0001 << $past(bus.level_code)))
        else $error("tap select does not match level code");
    AST_TAP_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !$past(bus.power_enable) |-> tap_select == 32'h0000_0000)
        else $error("tap selected while ladder powered down");
endmodule

`default_nettype wire

// file: verilog/lrc_top.sv
/*
 * Ladder reference control: AHB-Lite register slave and the control lines
 * that steer the analog ladder, its source mux and the output pin switch.
 * Assumes one clock, one slave on the bus, and the analog ladder outside.
 */
`default_nettype none

module lrc_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog ladder control
    output logic ladder_power_enable,
    output logic reference_pin_connect,
    output logic reference_source_select,
    output logic [4:0] ladder_level_code,
    output logic [31:0] ladder_tap_select
);
    typedef enum logic [1:0] {
        LRC_IDLE = 2'h1,
        LRC_WRITE = 2'h2
    } lrc_phase_type;

    lrc_bus_if bus ();

    logic [7:0] ladder_reference_control;
    logic [7:0] next_ladder_reference_control;
    lrc_phase_type phase;
    lrc_phase_type next_phase;
    logic [11:0] wr_addr;
    logic [11:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic addr_valid;
    logic [31:0] tap_q;
    logic next_hreadyout;
    logic next_hresp;
    logic next_ladder_power_enable;
    logic next_reference_pin_connect;
    logic next_reference_source_select;
    logic [4:0] next_ladder_level_code;
    logic [31:0] next_ladder_tap_select;

    function automatic logic lrc_hit(input logic [11:0] addr);
        lrc_hit = (addr & lrc_pkg::ADDR_MASK) == lrc_pkg::CTRL_OFFSET;
    endfunction

    // ------------------------------------------------------------
    // address phase
    // ------------------------------------------------------------
    always_comb begin
        // transfer size is not decoded: only whole words are expected
        addr_valid = hsel && hready && htrans[1];
    end

    // ------------------------------------------------------------
    // register and data phase
    // ------------------------------------------------------------
    always_comb begin
        next_phase = LRC_IDLE;
        next_wr_addr = wr_addr;
        next_ladder_reference_control = ladder_reference_control;
        next_hrdata = hrdata;
        unique case (phase)
            LRC_IDLE: begin
            end
            LRC_WRITE: begin
                // all fields updated together from the data phase
                if (lrc_hit(wr_addr)) begin
                    next_ladder_reference_control = hwdata[7:0];
                end
            end
        endcase
        if (addr_valid && hwrite) begin
            next_phase = LRC_WRITE;
            next_wr_addr = haddr[11:0];
        end
        // a read behind a write in its data phase sees the new value
        if (addr_valid && !hwrite) begin
            // unmapped words read as zero, upper bits read as zero
            next_hrdata = lrc_hit(haddr[11:0])
                ? {24'h00_0000, next_ladder_reference_control} : 32'h0000_0000;
        end
    end

    // no sleep or wake input: only bus writes and reset alter the register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= LRC_IDLE;
            wr_addr <= 12'h000;
            ladder_reference_control <= lrc_pkg::CTRL_RESET;
            hrdata <= 32'h0000_0000;
        end else begin
            phase <= next_phase;
            wr_addr <= next_wr_addr;
            ladder_reference_control <= next_ladder_reference_control;
            hrdata <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // bus response and analog control outputs
    // ------------------------------------------------------------
    always_comb begin
        // zero wait states: the slave never stalls and never errors
        next_hreadyout = 1'h1;
        next_hresp = lrc_pkg::HRESP_OKAY;
        next_ladder_power_enable = ladder_reference_control[lrc_pkg::POWER_BIT];
        // pin switch driven by the pin bit alone, no comparator term
        next_reference_pin_connect = ladder_reference_control[lrc_pkg::PIN_BIT];
        next_reference_source_select = ladder_reference_control[lrc_pkg::SOURCE_BIT];
        next_ladder_level_code = ladder_reference_control[lrc_pkg::LEVEL_MSB:0];
        // tap word lags the fields by one cycle more, through the decoder
        next_ladder_tap_select = tap_q;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'h1;
            hresp <= lrc_pkg::HRESP_OKAY;
            ladder_power_enable <= 1'h0;
            reference_pin_connect <= 1'h0;
            reference_source_select <= 1'h0;
            ladder_level_code <= 5'h00;
            ladder_tap_select <= 32'h0000_0000;
        end else begin
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
            ladder_power_enable <= next_ladder_power_enable;
            reference_pin_connect <= next_reference_pin_connect;
            reference_source_select <= next_reference_source_select;
            ladder_level_code <= next_ladder_level_code;
            ladder_tap_select <= next_ladder_tap_select;
        end
    end

    assign bus.level_code = ladder_reference_control[lrc_pkg::LEVEL_MSB:0];
    assign bus.power_enable = ladder_reference_control[lrc_pkg::POWER_BIT];
    assign tap_q = bus.tap_select;

    lrc_tap_decode u_tap (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .bus(bus)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_WRITE_TAKES: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (phase == LRC_WRITE && lrc_hit(wr_addr))
        |=> ladder_reference_control == $past(hwdata[7:0]))
        else $error("write did not store data");
    AST_MISS_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (phase == LRC_WRITE && !lrc_hit(wr_addr)) |=> $stable(ladder_reference_control))
        else $error("write to unmapped word changed control");
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (phase != LRC_WRITE) |=> $stable(ladder_reference_control))
        else $error("control changed without write");
    AST_READ_BACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (addr_valid && !hwrite && lrc_hit(haddr[11:0]) && phase == LRC_IDLE)
        |=> hrdata == {24'h00_0000, ladder_reference_control})
        else $error("read data wrong");
    AST_READ_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (addr_valid && !hwrite && !lrc_hit(haddr[11:0])) |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_OKAY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hreadyout && hresp == lrc_pkg::HRESP_OKAY)
        else $error("slave not ready or not okay");

    // ------------------------------------------------------------
    // output checks
    // ------------------------------------------------------------
    AST_POWER: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 ladder_power_enable == $past(ladder_reference_control[lrc_pkg::POWER_BIT]))
        else $error("power enable not following its bit");
    AST_PIN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 reference_pin_connect == $past(ladder_reference_control[lrc_pkg::PIN_BIT]))
        else $error("pin connect not following its bit");
    AST_SOURCE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 reference_source_select == $past(ladder_reference_control[lrc_pkg::SOURCE_BIT]))
        else $error("source select not following its bit");
    AST_LEVEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 ladder_level_code == $past(ladder_reference_control[lrc_pkg::LEVEL_MSB:0]))
        else $error("level code not following its field");
    AST_PIN_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !ladder_reference_control[lrc_pkg::PIN_BIT] |=> !reference_pin_connect)
        else $error("pin connected with pin bit clear");
    AST_TAP_PATH: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !ladder_reference_control[lrc_pkg::POWER_BIT] ##1 !bus.power_enable
        |=> ladder_tap_select == 32'h0000_0000)
        else $error("tap selected while powered down");
    AST_TAP_OUT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ##1 ladder_tap_select == $past(tap_q))
        else $error("tap output not following decoder");
    // no disable here: this one watches the reset itself
    AST_RESET_CLEAR: assert property (@(posedge sys_clk)
        !arst_n |-> !ladder_power_enable && !reference_pin_connect
            && ladder_reference_control == lrc_pkg::CTRL_RESET)
        else $error("reset did not clear control");
endmodule

`default_nettype wire
